// file: snc_defs.vh
// Purpose: constants for the sensor node commissioning block
// Assumes: 20 MHz clock, APB register access
// Notes: offsets are byte addresses of 32-bit words
`ifndef SNC_DEFS_VH
`define SNC_DEFS_VH
`define SNC_CLK_HZ 20000000
`define SNC_BAUD 9600
`define SNC_BAUD_DIV ((`SNC_CLK_HZ + `SNC_BAUD / 2) / `SNC_BAUD)
// register offsets
`define SNC_OFF_CTRL 12'h000
`define SNC_OFF_STAT 12'h004
`define SNC_OFF_NODE 12'h008
`define SNC_OFF_RATE 12'h00C
`define SNC_OFF_HBEAT 12'h010
`define SNC_OFF_TX1ID 12'h014
`define SNC_OFF_TX2ID 12'h018
`define SNC_OFF_TX3ID 12'h01C
`define SNC_OFF_TYPES 12'h020
`define SNC_OFF_PER1 12'h024
`define SNC_OFF_PER2 12'h028
`define SNC_OFF_UTX 12'h02C
`define SNC_OFF_URX 12'h030
`define SNC_OFF_ID 12'h034
// reset values
`define SNC_RST_NODE 7'h64
`define SNC_OFS_TX1 11'h180
`define SNC_OFS_TX2 11'h280
`define SNC_OFS_TX3 11'h380
`define SNC_RST_RATE 16'h00FA
`define SNC_RST_HBEAT 16'h03E8
`define SNC_RST_PER 16'h1388
`define SNC_RST_TYPE 8'hFF
`define SNC_RST_BUS_EN 1'b0
// status bits
`define SNC_ST_BUS 0
`define SNC_ST_ID_DONE 1
`define SNC_ST_TX_BUSY 2
`define SNC_ST_RX_VALID 3
`define SNC_ST_NODE_PEND 4
`define SNC_ST_EN_PEND 5
`define SNC_ST_SER_EN 6
`define SNC_ST_RX_ERR 7
`endif

// file: snc_core.v
// Purpose: commissioning state, serial port and bus parameter store
// Assumes: firmware parses serial commands and writes the registers
// Notes: bus enable and node number take effect after restart
//
// Notes on behaviour
// - after reset, send identification bytes on serial before accepting commands
// - delivered: serial link enabled, bus disabled, stored bus enable zero
// - bus enabled permanently only by the serial bus-enable command
// - node number 0x64; object1 ident node+0x180, own command changes it
// - object2 ident node+0x280, settable by its own command
// - object3 ident node+0x380, never directly writable
// - rate 250 kbit/s, heartbeat 1000 ms, periods 5000 ms, each settable
// - types 255; object3 type and object3 period follow object2
// - serial link keeps working while bus is enabled
// - serial 9600 baud, 8 data, 1 stop, no parity, no flow
// - unknown command echoed back prefixed by a question mark
// - bus enable and node number stored, applied at next restart
//
// The implementer's own choices: register access over APB and the address map.
`include "snc_defs.vh"
`default_nettype none
module snc_core #(
  parameter [31:0] ID_WORD = 32'h0000_1234 // arbitrary identification
) (
  // clock and reset
  input wire MCLK_I,
  input wire SRST_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output wire [31:0] PRDATA_O,
  output wire PREADY_O,
  output wire PSLVERR_O,
  // serial link
  input wire RXD_I,
  output reg TXD_O,
  // live bus configuration
  output reg BUS_ENABLE_O,
  output reg [6:0] NODE_NUMBER_O
);
  // -------------------------------------------------------------
  // stored settings
  // -------------------------------------------------------------
  reg stored_bus_en;
  reg [6:0] stored_node;
  reg [10:0] tx1_id, tx2_id;
  reg tx1_id_set, tx2_id_set;
  reg [15:0] bitrate, hbeat, per1, per2;
  reg [7:0] type1, type2;
  reg id_done;
  reg [2:0] id_idx;
  reg [31:0] prdata;
  reg rx_valid, rx_err;
  reg [7:0] rx_data;
  wire wr = PSEL_I & PENABLE_I & PWRITE_I;
  // bit time in clocks; slices keep the counters at 16 bits
  wire [31:0] baud_div = `SNC_BAUD_DIV;
  wire rd = PSEL_I & PENABLE_I & ~PWRITE_I;
  wire [10:0] node_ext = {4'h0, NODE_NUMBER_O};
  // -------------------------------------------------------------
  // transmitter
  // -------------------------------------------------------------
  localparam S_IDLE = 2'b01;
  localparam S_SEND = 2'b10;
  reg [1:0] tx_state;
  reg [15:0] tx_cnt;
  reg [3:0] tx_bit;
  reg [9:0] tx_shift;
  reg tx_load;
  reg [7:0] tx_byte;
  wire tx_busy = (tx_state != S_IDLE);
  wire tx_tick = (tx_cnt == 16'h0000);
  function decode_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      decode_hit = (a == off);
    end
  endfunction
  // firmware replies, the question-mark echo among them, leave here
  wire host_tx = wr & decode_hit(PADDR_I, `SNC_OFF_UTX)
    & id_done & ~tx_busy;
  always @* begin
    tx_load = 1'b0;
    tx_byte = PWDATA_I[7:0];
    if (!id_done && !tx_busy) begin
      tx_load = 1'b1;
      tx_byte = ID_WORD[31 - {id_idx[1:0], 3'b000} -: 8];
    end else if (host_tx) begin
      tx_load = 1'b1;
    end
  end
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      tx_state <= S_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 4'h0;
      tx_shift <= 10'h3FF;
      TXD_O <= 1'b1;
      id_done <= 1'b0;
      id_idx <= 3'h0;
    end else begin
      case (tx_state)
        S_IDLE: begin
          TXD_O <= 1'b1;
          if (tx_load) begin
            // 8N1 frame: start, data lsb first, stop
            tx_shift <= {1'b1, tx_byte, 1'b0};
            tx_cnt <= baud_div[15:0] - 16'h0001;
            tx_bit <= 4'h0;
            tx_state <= S_SEND;
            TXD_O <= 1'b0;
            if (!id_done) begin
              id_idx <= id_idx + 3'h1;
              if (id_idx == 3'h3)
                id_done <= 1'b1;
            end
          end
        end
        S_SEND: begin
          if (tx_tick) begin
            if (tx_bit == 4'h9) begin
              tx_state <= S_IDLE;
              TXD_O <= 1'b1;
            end else begin
              tx_bit <= tx_bit + 4'h1;
              TXD_O <= tx_shift[tx_bit + 4'h1];
              tx_cnt <= baud_div[15:0] - 16'h0001;
            end
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        default: tx_state <= S_IDLE;
      endcase
    end
  end
  // -------------------------------------------------------------
  // receiver
  // -------------------------------------------------------------
  reg rx_m, rx_s;
  reg rx_busy;
  reg [15:0] rx_cnt;
  reg [3:0] rx_bit;
  reg [7:0] rx_sh;
  wire rx_pop = rd & decode_hit(PADDR_I, `SNC_OFF_URX);
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
      rx_busy <= 1'b0;
      rx_cnt <= 16'h0000;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      rx_m <= RXD_I;
      rx_s <= rx_m;
      if (rx_pop)
        rx_valid <= 1'b0;
      // clear first, so a framing error in the same cycle still sets
      if (rd && decode_hit(PADDR_I, `SNC_OFF_STAT))
        rx_err <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s) begin
          rx_busy <= 1'b1;
          rx_cnt <= baud_div[16:1];
          rx_bit <= 4'h0;
        end
      end else if (rx_cnt != 16'h0000) begin
        rx_cnt <= rx_cnt - 16'h0001;
      end else begin
        rx_cnt <= baud_div[15:0] - 16'h0001;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s)
          rx_busy <= 1'b0; // false start
        else if (rx_bit == 4'h9) begin
          rx_busy <= 1'b0;
          if (rx_s) begin
            rx_data <= rx_sh;
            rx_valid <= 1'b1; // set wins over pop
          end else
            rx_err <= 1'b1;
        end else if (rx_bit != 4'h0)
          rx_sh <= {rx_s, rx_sh[7:1]};
      end
    end
  end
  // -------------------------------------------------------------
  // settings store, written by firmware acting on serial commands
  // -------------------------------------------------------------
  always @(posedge MCLK_I) begin
    if (SRST_I) begin
      // live values take stored ones only here
      BUS_ENABLE_O <= stored_bus_en;
      NODE_NUMBER_O <= stored_node;
      bitrate <= `SNC_RST_RATE;
      hbeat <= `SNC_RST_HBEAT;
      per1 <= `SNC_RST_PER;
      per2 <= `SNC_RST_PER;
      type1 <= `SNC_RST_TYPE;
      type2 <= `SNC_RST_TYPE;
      tx1_id_set <= 1'b0;
      tx2_id_set <= 1'b0;
      tx1_id <= 11'h000;
      tx2_id <= 11'h000;
    end else if (wr && id_done) begin
      // commands held off until the last identification byte is loaded
      case (PADDR_I)
        `SNC_OFF_RATE: bitrate <= PWDATA_I[15:0];
        `SNC_OFF_HBEAT: hbeat <= PWDATA_I[15:0];
        `SNC_OFF_PER1: per1 <= PWDATA_I[15:0];
        `SNC_OFF_PER2: per2 <= PWDATA_I[15:0];
        `SNC_OFF_TYPES: begin
          type1 <= PWDATA_I[7:0];
          type2 <= PWDATA_I[15:8];
        end
        `SNC_OFF_TX1ID: begin
          tx1_id <= PWDATA_I[10:0];
          tx1_id_set <= 1'b1;
        end
        `SNC_OFF_TX2ID: begin
          tx2_id <= PWDATA_I[10:0];
          tx2_id_set <= 1'b1;
        end
        default: ;
      endcase
    end
  end
  // stored values survive reset; only power-up loads the defaults
  initial stored_bus_en = `SNC_RST_BUS_EN;
  initial stored_node = `SNC_RST_NODE;
  always @(posedge MCLK_I) begin
    if (!SRST_I && wr && id_done) begin
      if (decode_hit(PADDR_I, `SNC_OFF_CTRL))
        stored_bus_en <= PWDATA_I[0];
      if (decode_hit(PADDR_I, `SNC_OFF_NODE))
        stored_node <= PWDATA_I[6:0];
    end
  end
  // -------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------
  wire [10:0] id1 = tx1_id_set ? tx1_id : node_ext + `SNC_OFS_TX1;
  wire [10:0] id2 = tx2_id_set ? tx2_id : node_ext + `SNC_OFS_TX2;
  wire [10:0] id3 = node_ext + `SNC_OFS_TX3;
  wire [7:0] stat = {rx_err, 1'b1,
    stored_bus_en != BUS_ENABLE_O, stored_node != NODE_NUMBER_O,
    rx_valid, tx_busy, id_done, BUS_ENABLE_O};
  always @* begin
    case (PADDR_I)
      `SNC_OFF_CTRL: prdata = {31'h0, stored_bus_en};
      `SNC_OFF_STAT: prdata = {24'h0, stat};
      `SNC_OFF_NODE: prdata = {25'h0, stored_node};
      `SNC_OFF_RATE: prdata = {16'h0, bitrate};
      `SNC_OFF_HBEAT: prdata = {16'h0, hbeat};
      `SNC_OFF_TX1ID: prdata = {21'h0, id1};
      `SNC_OFF_TX2ID: prdata = {21'h0, id2};
      `SNC_OFF_TX3ID: prdata = {21'h0, id3};
      `SNC_OFF_TYPES: prdata = {8'h00, type2, type2, type1};
      `SNC_OFF_PER1: prdata = {16'h0, per1};
      `SNC_OFF_PER2: prdata = {per2, per2};
      `SNC_OFF_URX: prdata = {24'h0, rx_data};
      `SNC_OFF_ID: prdata = ID_WORD;
      default: prdata = 32'h0000_0000;
    endcase
  end
  assign PRDATA_O = rd ? prdata : 32'h0000_0000;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & (PADDR_I > `SNC_OFF_ID);
endmodule // snc_core
`default_nettype wire

// file: snc_core_sva.sv
// Purpose: port checks for the commissioning block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to every instance of snc_core
`default_nettype none
module snc_core_sva #(
  parameter logic [31:0] ID_WORD = 32'h0000_1234
) (
  input wire logic MCLK_I, SRST_I, PSEL_I, PENABLE_I, PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O, PSLVERR_O, TXD_O, BUS_ENABLE_O,
  input wire logic [6:0] NODE_NUMBER_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  wire logic rd_acc = PSEL_I && PENABLE_I && !PWRITE_I;
  bus_live_hold_a: assert property ($stable(BUS_ENABLE_O))
    else $error("live bus enable moved outside reset");
  node_live_hold_a: assert property ($stable(NODE_NUMBER_O))
    else $error("live node number moved outside reset");
  tx_idle_a: assert property ($fell(SRST_I) |-> TXD_O)
    else $error("serial line not idle after reset");
  start_bit_a: assert property ($fell(TXD_O) |-> !TXD_O [*8])
    else $error("start bit too short");
  ident_word_a: assert property (rd_acc && PADDR_I == 12'h034
    |-> PRDATA_O == ID_WORD) else $error("identification word wrong");
  zero_wait_a: assert property (PSEL_I && PENABLE_I |-> PREADY_O)
    else $error("access phase without ready");
  unmapped_err_a: assert property (PSEL_I && PENABLE_I && PADDR_I > 12'h034
    |-> PSLVERR_O && PRDATA_O == 32'h0) else $error("unmapped not refused");
  idle_rdata_a: assert property (!rd_acc |-> PRDATA_O == 32'h0)
    else $error("read data outside read access");
endmodule // snc_core_sva
bind snc_core snc_core_sva #(.ID_WORD(ID_WORD)) i_snc_core_sva (
  .MCLK_I(MCLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .TXD_O(TXD_O), .BUS_ENABLE_O(BUS_ENABLE_O),
  .NODE_NUMBER_O(NODE_NUMBER_O));
`default_nettype wire

// file: snc_host.sv
// Purpose: serial host terminal model, receives identification bytes
// Assumes: 8N1 at the divisor from the shared constants
// Notes: sends one command byte when asked, idle mark level otherwise
`include "snc_defs.vh"
`default_nettype none
module snc_host (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic go_i,
  input wire logic [7:0] byte_i,
  output logic rxd_o,
  output logic [31:0] word_o,
  output int n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] b;
  initial begin
    word_o = 32'h0;
    n_o = 0;
    forever begin
      @(negedge txd_i);
      // sample mid-bit to stay clear of edge skew
      repeat (`SNC_BAUD_DIV / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (`SNC_BAUD_DIV) @(posedge clk_i);
        if (i < 8) b = {txd_i, b[7:1]};
      end
      if (txd_i === 1'b1) begin
        word_o = {word_o[23:0], b};
        n_o++;
      end
    end
  end
  // one 8N1 frame towards the block, lsb first
  initial begin
    rxd_o <= 1'b1;
    wait (go_i === 1'b1);
    @(posedge clk_i);
    for (int j = 0; j < 10; j++) begin
      rxd_o <= (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : byte_i[j - 1];
      repeat (`SNC_BAUD_DIV) @(posedge clk_i);
    end
  end
endmodule // snc_host
`default_nettype wire

// file: snc_core_tb.sv
// Purpose: self-checking bench for snc_core
// Assumes: 20 MHz clock, APB master, host model on the serial pins
// Notes: second reset models a restart
`include "snc_defs.vh"
`default_nettype none
module snc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rxd;
  logic host_go = 0;
  localparam logic [31:0] TB_ID = 32'h5A3C_0F81; // arbitrary
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, hword;
  logic pready, pslverr, txd, bus_en;
  logic [6:0] node;
  int n_errors = 0, n_tests = 0, hn;
  snc_core #(.ID_WORD(TB_ID)) i_snc_core (.MCLK_I(clk), .SRST_I(srst),
    .PSEL_I(psel),
    .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .RXD_I(rxd), .TXD_O(txd),
    .BUS_ENABLE_O(bus_en), .NODE_NUMBER_O(node));
  snc_host i_snc_host (.clk_i(clk), .txd_i(txd), .go_i(host_go),
    .byte_i(8'hC5), .rxd_o(rxd),
    .word_o(hword), .n_o(hn));
  initial forever #25 clk = ~clk;
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin n_errors++; tally_and_finish(); end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, "read");
  endtask
  task automatic t_defaults;
    rd(12'h008, 32'h0000_0064);
    rd(12'h000, 32'h0000_0000);
    rd(12'h00C, 32'h0000_00FA);
    rd(12'h010, 32'h0000_03E8);
    rd(12'h014, 32'h0000_01E4);
    rd(12'h018, 32'h0000_02E4);
    rd(12'h01C, 32'h0000_03E4);
    rd(12'h020, 32'h00FF_FFFF);
    rd(12'h024, 32'h0000_1388);
    rd(12'h028, 32'h1388_1388);
    rd(12'h034, TB_ID);
    chk({24'h0, node, bus_en}, {24'h0, 7'h64, 1'b0}, "live");
    $display("defaults done");
  endtask
  task automatic t_early;
    wr(12'h000, 32'h0000_0001);
    rd(12'h000, 32'h0000_0000);
    $display("early write done");
  endtask
  task automatic t_ident;
    logic [31:0] r;
    logic e;
    int k;
    host_go <= 1'b1;
    for (k = 0; k < 90000 && hn < 4; k++) @(posedge clk);
    if (hn < 4) begin n_errors++; tally_and_finish(); end
    chk(hword, TB_ID, "ident");
    r = 32'h4;
    for (k = 0; k < 2000 && r[2]; k++) apb(1'b0, 12'h004, 32'h0, r, e);
    if (r[2]) begin n_errors++; tally_and_finish(); end
    chk({29'h0, r[6], r[3], r[1]}, 32'h7, "status");
    wr(12'h02C, 32'h0000_003F);
    rd(12'h004, 32'h0000_004E);
    rd(12'h030, 32'h0000_00C5);
    $display("ident done");
  endtask
  task automatic t_config;
    logic [31:0] r;
    logic e;
    wr(12'h008, 32'h0000_0010);
    wr(12'h014, 32'h0000_0123);
    wr(12'h018, 32'h0000_0234);
    wr(12'h01C, 32'h0000_0555);
    wr(12'h00C, 32'h0000_01F4);
    wr(12'h010, 32'h0000_01F4);
    wr(12'h020, 32'h0000_0102);
    wr(12'h024, 32'h0000_0BB8);
    wr(12'h028, 32'h0000_07D0);
    wr(12'h000, 32'h0000_0001);
    rd(12'h014, 32'h0000_0123);
    rd(12'h018, 32'h0000_0234);
    rd(12'h01C, 32'h0000_03E4);
    rd(12'h00C, 32'h0000_01F4);
    rd(12'h010, 32'h0000_01F4);
    rd(12'h020, 32'h0001_0102);
    rd(12'h024, 32'h0000_0BB8);
    rd(12'h028, 32'h07D0_07D0);
    rd(12'h000, 32'h0000_0001);
    rd(12'h004, 32'h0000_0076);
    chk({24'h0, node, bus_en}, {24'h0, 7'h64, 1'b0}, "held");
    apb(1'b0, 12'h038, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000, "unmapped");
    $display("config done");
  endtask
  task automatic t_restart;
    logic [31:0] r;
    logic e;
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    chk({24'h0, node, bus_en}, {24'h0, 7'h10, 1'b1}, "live");
    rd(12'h01C, 32'h0000_0390);
    apb(1'b0, 12'h004, 32'h0, r, e);
    chk({31'h0, r[6]}, 32'h1, "serial on");
    $display("restart done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 0;
    t_defaults();
    t_early();
    t_ident();
    t_config();
    t_restart();
    tally_and_finish();
  end
endmodule // snc_core_tb
`default_nettype wire
